// file: include/rof_pkg.sv
// constants shared by the reading output formatter
package rof_pkg;
    // register map, byte addresses on the plain register port
    localparam logic [3:0] ADDR_CONFIG = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    // config register fields
    localparam int CFG_FMT_LSB = 0;
    localparam int CFG_ORDER_BIT = 2;
    localparam int CFG_ELEM_LSB = 4;
    localparam logic [7:0] CFG_RESET = 8'h10;
    // status register fields
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_LEVEL_LSB = 4;
    // format codes; code 3 behaves as text
    localparam logic [1:0] FMT_TEXT = 2'h0;
    localparam logic [1:0] FMT_SINGLE = 2'h1;
    localparam logic [1:0] FMT_DOUBLE = 2'h2;
    // element select bits
    localparam int ELEM_READ = 0;
    localparam int ELEM_CHAN = 1;
    localparam int ELEM_UNITS = 2;
    // characters
    localparam logic [7:0] CH_HASH = 8'h23;
    localparam logic [7:0] CH_ZERO = 8'h30;
    localparam logic [7:0] CH_DOT = 8'h2E;
    localparam logic [7:0] CH_EXP = 8'h45;
    localparam logic [7:0] CH_PLUS = 8'h2B;
    localparam logic [7:0] CH_MINUS = 8'h2D;
    localparam logic [7:0] CH_COMMA = 8'h2C;
    localparam logic [23:0] UNIT_INT = 24'h49_4E54;
    localparam logic [23:0] UNIT_EXT = 24'h45_5854;
    // overflow reading, +9.9e37
    localparam logic [63:0] OVF_DOUBLE = 64'h47D2_9EAD_2000_0000;
    localparam logic [31:0] OVF_MANT_BCD = 32'h9900_0000;
    localparam logic [7:0] OVF_EXP_BCD = 8'h37;
    localparam logic [2:0] OVF_RES = 3'h1;
    // floating point layouts
    localparam int SGL_EXP_W = 8;
    localparam int SGL_FRAC_W = 23;
    localparam int DBL_EXP_W = 11;
    localparam int DBL_FRAC_W = 52;
    localparam logic [10:0] DBL_BIAS = 11'h3FF;
    localparam logic [10:0] BIAS_DIFF = 11'h380;
    localparam logic [10:0] SGL_EXP_TOP = 11'h47E;
    localparam logic [10:0] DBL_EXP_ALL = 11'h7FF;
    localparam logic [31:0] SGL_INF = 32'h7F80_0000;
    localparam logic [31:0] SGL_NAN = 32'h7FC0_0000;
    localparam logic [3:0] SGL_BYTES = 4'h4;
    localparam logic [3:0] DBL_BYTES = 4'h8;
    // text field lengths
    localparam logic [4:0] TXT_RD_FIXED = 5'h07;
    localparam logic [4:0] TXT_CH_DIGITS = 5'h04;
    localparam logic [4:0] TXT_UNIT_LEN = 5'h03;
    localparam logic [4:0] HDR_LEN = 5'h02;
endpackage

// file: logic/reading_output_formatter.sv
// reading output formatter: builds text or binary data strings per reading
// Behaviour
// - output encodings are text, single precision binary and double precision binary.
// - each reading conversion emits one string with the selected elements; the reading alone when neither reading nor channel is selected.
// - single precision puts each selected element in one 32-bit block.
// - binary strings start with a two byte header, hash then zero.
// - single values carry sign, 8 exponent bits, 23 fraction bits.
// - double values are 64 bits: sign, 11 exponent bits, 52 fraction bits.
// - normal order sends byte 1 first, swapped order sends the last byte first.
// - header is never reordered and is sent once, first, per string.
// - text always goes out in normal order; swapped setting ignored.
// - overflow reading goes out as +9.9e37 without units.
// - channel element carries scan channel number, zero when not scanning.
// - units tag reading and channel, internal or external; absent in binary.
// - elements always go out in fixed order, reading then channel.
// - reading resolution follows the configured display resolution.
// - latest reading and calculation queries always go out as normal text.
`timescale 1ns/1ps

module rof_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 8
) (
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    input wire logic [WIDTH-1:0] i_data,
    input wire logic i_valid,
    output logic o_ready,
    output logic [WIDTH-1:0] o_data,
    output logic o_valid,
    input wire logic i_ready,
    output logic [$clog2(DEPTH):0] o_level
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_q;
    logic [AW:0] rd_q;
    logic push;
    logic pop;

    assign o_level = wr_q - rd_q;
    assign o_ready = o_level != (AW+1)'(DEPTH);
    assign o_valid = wr_q != rd_q;
    assign o_data = mem[rd_q[AW-1:0]];
    assign push = i_valid && o_ready;
    assign pop = o_valid && i_ready;

    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            wr_q <= '0;
        end else if (push) begin
            wr_q <= wr_q + 1'b1;
        end
    end

    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            rd_q <= '0;
        end else if (pop) begin
            rd_q <= rd_q + 1'b1;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (push) begin
            mem[wr_q[AW-1:0]] <= i_data;
        end
    end
endmodule

module reading_output_formatter
    import rof_pkg::*;
#(
    parameter int FIFO_DEPTH = 8
) (
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    input wire logic [3:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    output logic [7:0] o_reg_rdata,
    input wire logic i_start,
    output logic o_start_ready,
    input wire logic i_from_buffer,
    input wire logic i_overflow,
    input wire logic [63:0] i_reading,
    input wire logic i_read_neg,
    input wire logic [31:0] i_mant_bcd,
    input wire logic i_exp_neg,
    input wire logic [7:0] i_exp_bcd,
    input wire logic [2:0] i_resolution,
    input wire logic [23:0] i_unit_text,
    input wire logic i_scanning,
    input wire logic i_chan_ext,
    input wire logic [9:0] i_chan,
    output logic [7:0] o_byte,
    output logic o_byte_last,
    output logic o_byte_valid,
    input wire logic i_byte_ready
);
    typedef enum logic [2:0] {S_IDLE, S_HDR, S_READ, S_SEP, S_CHAN} state_t;

    state_t state_q;
    logic [7:0] cfg_q;
    logic [7:0] rdata_q;
    logic [1:0] fmt_q;
    logic swap_q;
    logic [2:0] elem_q;
    logic ovf_q;
    logic neg_q;
    logic [31:0] mant_q;
    logic eneg_q;
    logic [7:0] exp_q;
    logic [2:0] res_q;
    logic [23:0] unit_q;
    logic [63:0] rd_word_q;
    logic [63:0] ch_word_q;
    logic [15:0] ch_bcd_q;
    logic chext_q;
    logic [4:0] idx_q;
    logic [1:0] fmt_sel;
    logic [2:0] elem_sel;
    logic [9:0] chan_val;
    logic bin;
    logic [3:0] nbytes;
    logic [4:0] len;
    logic [7:0] cur_byte;
    logic elem_end;
    logic str_end;
    logic push;
    logic fifo_in_ready;
    logic [$clog2(FIFO_DEPTH):0] level;

    function automatic logic [7:0] digit_char(input logic [3:0] d);
        digit_char = CH_ZERO + {4'h0, d};
    endfunction

    function automatic logic [7:0] sign_char(input logic neg);
        sign_char = neg ? CH_MINUS : CH_PLUS;
    endfunction

    // narrows a double by truncating the fraction; too large gives infinity, too small gives signed zero
    function automatic logic [31:0] dbl_to_sgl(input logic [63:0] d);
        logic [10:0] e;
        logic [31:0] r;
        e = d[62:DBL_FRAC_W];
        r = {d[63], d[62] ? d[61-:3] : 3'h0, d[DBL_FRAC_W-1-:SGL_EXP_W-3],
             d[DBL_FRAC_W-1-:SGL_FRAC_W]};
        r[30:SGL_FRAC_W] = 8'(e - BIAS_DIFF);
        if (e == DBL_EXP_ALL) begin
            r = (d[DBL_FRAC_W-1:0] != '0) ? SGL_NAN : (SGL_INF | {d[63], 31'h0});
        end else if (e > SGL_EXP_TOP) begin
            r = SGL_INF | {d[63], 31'h0};
        end else if (e <= BIAS_DIFF) begin
            r = {d[63], 31'h0};
        end
        dbl_to_sgl = r;
    endfunction

    function automatic logic [63:0] int_to_dbl(input logic [9:0] v);
        logic [3:0] p;
        logic [63:0] r;
        p = 4'h0;
        r = '0;
        for (int i = 0; i < 10; i++) begin
            if (v[i]) begin
                p = 4'(i);
            end
        end
        if (v != '0) begin
            r[62:DBL_FRAC_W] = DBL_BIAS + {7'h0, p};
            r[DBL_FRAC_W-1:0] = 52'({v, 42'h0} << (5'd10 - {1'b0, p}));
        end
        int_to_dbl = r;
    endfunction

    function automatic logic [15:0] bin_to_bcd(input logic [9:0] v);
        logic [25:0] s;
        s = {16'h0, v};
        for (int i = 0; i < 10; i++) begin
            for (int k = 0; k < 4; k++) begin
                if (s[10+4*k+:4] > 4'h4) begin
                    s[10+4*k+:4] = s[10+4*k+:4] + 4'h3;
                end
            end
            s = s << 1;
        end
        bin_to_bcd = s[25:10];
    endfunction

    // byte 1 is the most significant; swap counts down from the last
    function automatic logic [7:0] bin_byte(input logic [63:0] w, input logic [4:0] i,
                                            input logic sw, input logic [3:0] n);
        logic [3:0] pos;
        logic [63:0] t;
        pos = sw ? (n - 4'h1 - i[3:0]) : i[3:0];
        t = w << {pos, 3'h0};
        bin_byte = t[63:56];
    endfunction

    // register port
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            cfg_q <= CFG_RESET;
        end else if (i_reg_wr && i_reg_addr == ADDR_CONFIG) begin
            cfg_q <= i_reg_wdata;
        end
    end

    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            rdata_q <= '0;
        end else if (i_reg_rd) begin
            unique case (i_reg_addr)
                ADDR_CONFIG: rdata_q <= cfg_q;
                ADDR_STATUS: rdata_q <= 8'({level, 3'h0, state_q != S_IDLE} << STAT_BUSY_BIT);
                default: rdata_q <= '0;
            endcase
        end else begin
            rdata_q <= '0;
        end
    end
    assign o_reg_rdata = rdata_q;

    // settings are frozen per string so a mid-string write cannot tear it
    always_comb begin
        fmt_sel = cfg_q[CFG_FMT_LSB+:2];
        if (!i_from_buffer || fmt_sel == 2'h3) begin
            fmt_sel = FMT_TEXT;
        end
        elem_sel = cfg_q[CFG_ELEM_LSB+:3];
        if (fmt_sel != FMT_TEXT) begin
            elem_sel[ELEM_UNITS] = 1'b0;
        end
        if (!elem_sel[ELEM_READ] && !elem_sel[ELEM_CHAN]) begin
            elem_sel[ELEM_READ] = 1'b1;
        end
        chan_val = i_scanning ? i_chan : 10'h0;
    end

    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            fmt_q <= FMT_TEXT;
            swap_q <= 1'b0;
            elem_q <= '0;
        end else if (i_start && o_start_ready) begin
            fmt_q <= fmt_sel;
            swap_q <= cfg_q[CFG_ORDER_BIT] && fmt_sel != FMT_TEXT;
            elem_q <= elem_sel;
        end
    end

    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ovf_q <= 1'b0;
            neg_q <= 1'b0;
            mant_q <= '0;
            eneg_q <= 1'b0;
            exp_q <= '0;
            res_q <= '0;
            unit_q <= '0;
            rd_word_q <= '0;
            ch_word_q <= '0;
            ch_bcd_q <= '0;
            chext_q <= 1'b0;
        end else if (i_start && o_start_ready) begin
            ovf_q <= i_overflow;
            neg_q <= i_read_neg && !i_overflow;
            mant_q <= i_overflow ? OVF_MANT_BCD : i_mant_bcd;
            eneg_q <= i_exp_neg && !i_overflow;
            exp_q <= i_overflow ? OVF_EXP_BCD : i_exp_bcd;
            res_q <= i_overflow ? OVF_RES : i_resolution;
            unit_q <= i_unit_text;
            chext_q <= i_chan_ext;
            ch_bcd_q <= bin_to_bcd(chan_val);
            if (fmt_sel == FMT_SINGLE) begin
                rd_word_q <= {dbl_to_sgl(i_overflow ? OVF_DOUBLE : i_reading), 32'h0};
                ch_word_q <= {dbl_to_sgl(int_to_dbl(chan_val)), 32'h0};
            end else begin
                rd_word_q <= i_overflow ? OVF_DOUBLE : i_reading;
                ch_word_q <= int_to_dbl(chan_val);
            end
        end
    end

    assign bin = fmt_q != FMT_TEXT;
    assign nbytes = (fmt_q == FMT_SINGLE) ? SGL_BYTES : DBL_BYTES;

    // current byte and element length
    always_comb begin
        logic [4:0] j;
        logic [4:0] u;
        j = '0;
        u = '0;
        cur_byte = '0;
        len = 5'h1;
        unique case (state_q)
            S_HDR: begin
                len = HDR_LEN;
                cur_byte = (idx_q == '0) ? CH_HASH : CH_ZERO;
            end
            S_READ: begin
                if (bin) begin
                    len = {1'b0, nbytes};
                    cur_byte = bin_byte(rd_word_q, idx_q, swap_q, nbytes);
                end else begin
                    len = TXT_RD_FIXED + {2'h0, res_q};
                    if (elem_q[ELEM_UNITS] && !ovf_q) begin
                        len = len + TXT_UNIT_LEN;
                    end
                    j = idx_q - 5'h3 - {2'h0, res_q};
                    u = j - 5'h4;
                    if (idx_q == 5'h0) begin
                        cur_byte = sign_char(neg_q);
                    end else if (idx_q == 5'h1) begin
                        cur_byte = digit_char(mant_q[31:28]);
                    end else if (idx_q == 5'h2) begin
                        cur_byte = CH_DOT;
                    end else if (idx_q < 5'h3 + {2'h0, res_q}) begin
                        cur_byte = digit_char(4'(mant_q << {idx_q - 5'h2, 2'h0} >> 28));
                    end else if (j == 5'h0) begin
                        cur_byte = CH_EXP;
                    end else if (j == 5'h1) begin
                        cur_byte = sign_char(eneg_q);
                    end else if (j == 5'h2) begin
                        cur_byte = digit_char(exp_q[7:4]);
                    end else if (j == 5'h3) begin
                        cur_byte = digit_char(exp_q[3:0]);
                    end else begin
                        cur_byte = unit_q[23 - 8 * u[1:0] -: 8];
                    end
                end
            end
            S_SEP: begin
                cur_byte = CH_COMMA;
            end
            S_CHAN: begin
                if (bin) begin
                    len = {1'b0, nbytes};
                    cur_byte = bin_byte(ch_word_q, idx_q, swap_q, nbytes);
                end else begin
                    len = TXT_CH_DIGITS + (elem_q[ELEM_UNITS] ? TXT_UNIT_LEN : 5'h0);
                    u = idx_q - TXT_CH_DIGITS;
                    if (idx_q < TXT_CH_DIGITS) begin
                        cur_byte = digit_char(ch_bcd_q[15 - 4 * idx_q[1:0] -: 4]);
                    end else begin
                        cur_byte = 8'((chext_q ? UNIT_EXT : UNIT_INT) >> (8'd16 - {u[2:0], 3'h0}));
                    end
                end
            end
            default: begin
                cur_byte = '0;
            end
        endcase
    end

    assign elem_end = idx_q == len - 5'h1;
    assign str_end = elem_end && ((state_q == S_READ && !elem_q[ELEM_CHAN]) || state_q == S_CHAN);
    assign push = state_q != S_IDLE && fifo_in_ready; // fifo back-pressure stalls the walk
    assign o_start_ready = state_q == S_IDLE;

    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            idx_q <= '0;
        end else if (push) begin
            idx_q <= elem_end ? 5'h0 : idx_q + 5'h1;
        end
    end

    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state_q <= S_IDLE;
        end else if (state_q == S_IDLE) begin
            if (i_start) begin
                if (fmt_sel != FMT_TEXT) begin
                    state_q <= S_HDR;
                end else begin
                    state_q <= elem_sel[ELEM_READ] ? S_READ : S_CHAN;
                end
            end
        end else if (push && elem_end) begin
            unique case (state_q)
                S_HDR: state_q <= elem_q[ELEM_READ] ? S_READ : S_CHAN;
                S_READ: begin
                    if (!elem_q[ELEM_CHAN]) begin
                        state_q <= S_IDLE;
                    end else begin
                        state_q <= bin ? S_CHAN : S_SEP;
                    end
                end
                S_SEP: state_q <= S_CHAN;
                S_CHAN: state_q <= S_IDLE;
                default: state_q <= S_IDLE;
            endcase
        end
    end

    rof_fifo #(
        .WIDTH(9),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .i_mclk(i_mclk),
        .i_sys_rst(i_sys_rst),
        .i_data({str_end, cur_byte}),
        .i_valid(state_q != S_IDLE),
        .o_ready(fifo_in_ready),
        .o_data({o_byte_last, o_byte}),
        .o_valid(o_byte_valid),
        .i_ready(i_byte_ready),
        .o_level(level)
    );
endmodule

// file: test/rof_host_model.sv
// host side model: takes formatter bytes with a regular stall and an optional long hold
`timescale 1ns/1ps
module rof_host_model (
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    input wire logic [7:0] i_byte,
    input wire logic i_last,
    input wire logic i_valid,
    input wire logic i_hold,
    output logic o_ready
);
    logic [1:0] cnt_q;
    logic [8:0] got[$];
    // a slow host drops ready one cycle in four, so the fifo never stays empty-fast
    assign o_ready = !i_hold && cnt_q != 2'h3;
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            cnt_q <= 2'h0;
        end else begin
            cnt_q <= cnt_q + 2'h1;
        end
    end
    always @(posedge i_mclk) begin
        if (!i_sys_rst && i_valid && o_ready) begin
            got.push_back({i_last, i_byte});
        end
    end
endmodule

// file: test/rof_checker.sv
// port assertions for the reading output formatter
`timescale 1ns/1ps
module rof_checker
    import rof_pkg::*;
#(
    parameter int FIFO_DEPTH = 8
) (
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    input wire logic [3:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] o_reg_rdata,
    input wire logic i_start,
    input wire logic o_start_ready,
    input wire logic [7:0] o_byte,
    input wire logic o_byte_last,
    input wire logic o_byte_valid,
    input wire logic i_byte_ready
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_sys_rst);
    sequence s_take;
        i_start && o_start_ready;
    endsequence
    sequence s_cfg_wr;
        i_reg_wr && i_reg_addr == ADDR_CONFIG;
    endsequence
    sequence s_cfg_rd;
        i_reg_rd && i_reg_addr == ADDR_CONFIG;
    endsequence
    a_rdata_idle: assert property (!i_reg_rd |=> o_reg_rdata == 8'h00)
        else $error("read data not zero outside read answer");
    // shortest string is a text channel alone, four digits
    a_take_busy: assert property (s_take |=> !o_start_ready [*4])
        else $error("start ready returned too early");
    a_first_byte: assert property (s_take |-> ##2 o_byte_valid)
        else $error("first byte late");
    a_stall_hold: assert property (o_byte_valid && !i_byte_ready |=>
        o_byte_valid && $stable(o_byte) && $stable(o_byte_last))
        else $error("byte changed while stalled");
    a_no_spurious: assert property (!o_byte_valid && o_start_ready && !i_start |=>
        !o_byte_valid)
        else $error("byte without request");
    a_unmapped_zero: assert property (i_reg_rd && i_reg_addr != ADDR_CONFIG &&
        i_reg_addr != ADDR_STATUS |=> o_reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_cfg_readback: assert property (s_cfg_wr ##1 s_cfg_rd |=>
        (o_reg_rdata & 8'h77) == ($past(i_reg_wdata, 2) & 8'h77))
        else $error("config readback wrong");
    a_idle_status: assert property (i_reg_rd && i_reg_addr == ADDR_STATUS && o_start_ready
        && !i_start ##1 o_start_ready |-> !o_reg_rdata[STAT_BUSY_BIT])
        else $error("busy seen while idle");
endmodule
bind reading_output_formatter rof_checker #(.FIFO_DEPTH(FIFO_DEPTH)) rof_checker_i (
    .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
    .o_reg_rdata(o_reg_rdata), .i_start(i_start), .o_start_ready(o_start_ready),
    .o_byte(o_byte), .o_byte_last(o_byte_last), .o_byte_valid(o_byte_valid),
    .i_byte_ready(i_byte_ready));

// file: test/tb.sv
// self-checking bench for the reading output formatter
`timescale 1ns/1ps
module tb;
    import rof_pkg::*;
    logic i_mclk = 1'b0, i_sys_rst = 1'b1, i_reg_wr = 1'b0, i_reg_rd = 1'b0, i_start = 1'b0;
    logic [3:0] i_reg_addr = 4'h0;
    logic [7:0] i_reg_wdata = 8'h00, o_reg_rdata, o_byte, i_exp_bcd = 8'h01;
    logic o_start_ready, o_byte_last, o_byte_valid, i_byte_ready, hold = 1'b0;
    logic i_from_buffer = 1'b1, i_overflow = 1'b0, i_read_neg = 1'b0, i_exp_neg = 1'b0;
    logic i_scanning = 1'b0, i_chan_ext = 1'b0;
    logic [63:0] i_reading = 64'h0;
    logic [31:0] i_mant_bcd = 32'h1234_5678;
    logic [2:0] i_resolution = 3'h2;
    logic [23:0] i_unit_text = 24'h56_4443;
    logic [9:0] i_chan = 10'h007;
    logic [7:0] exp_q[$];
    int err_total = 0, n_compared = 0;
    always #5 i_mclk = ~i_mclk;
    reading_output_formatter #(.FIFO_DEPTH(8)) reading_output_formatter_i (
        .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_reg_addr(i_reg_addr),
        .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
        .o_reg_rdata(o_reg_rdata), .i_start(i_start), .o_start_ready(o_start_ready),
        .i_from_buffer(i_from_buffer), .i_overflow(i_overflow), .i_reading(i_reading),
        .i_read_neg(i_read_neg), .i_mant_bcd(i_mant_bcd), .i_exp_neg(i_exp_neg),
        .i_exp_bcd(i_exp_bcd), .i_resolution(i_resolution), .i_unit_text(i_unit_text),
        .i_scanning(i_scanning), .i_chan_ext(i_chan_ext), .i_chan(i_chan), .o_byte(o_byte),
        .o_byte_last(o_byte_last), .o_byte_valid(o_byte_valid),
        .i_byte_ready(i_byte_ready));
    rof_host_model host_i (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_byte(o_byte),
        .i_last(o_byte_last), .i_valid(o_byte_valid), .i_hold(hold), .o_ready(i_byte_ready));
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        i_reg_addr <= a;
        i_reg_wdata <= d;
        i_reg_wr <= 1'b1;
        @(posedge i_mclk);
        i_reg_wr <= 1'b0;
    endtask
    task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge i_mclk);
        i_reg_addr <= a;
        i_reg_rd <= 1'b1;
        @(posedge i_mclk);
        i_reg_rd <= 1'b0;
        #1 d = o_reg_rdata;
    endtask
    task automatic add_s(input string s);
        foreach (s[i]) exp_q.push_back(s[i]);
    endtask
    // v is right aligned; sw sends the last byte first
    task automatic add_v(input logic [63:0] v, input int nb, input bit sw);
        for (int i = 0; i < nb; i++) exp_q.push_back(sw ? v[8*i+:8] : v[8*(nb-1-i)+:8]);
    endtask
    task automatic run(input logic [7:0] cfg, input string what);
        int n;
        logic [7:0] d;
        reg_wr(ADDR_CONFIG, cfg);
        host_i.got.delete();
        do @(negedge i_mclk); while (!o_start_ready);
        @(posedge i_mclk) i_start <= 1'b1;
        @(posedge i_mclk) i_start <= 1'b0;
        if (hold) begin
            repeat (40) @(posedge i_mclk);
            reg_rd(ADDR_STATUS, d);
            check("status full", {8'h0, d}, 16'h0081);
            @(posedge i_mclk) hold <= 1'b0;
        end
        n = 0;
        while (host_i.got.size() < exp_q.size() && n < 400) begin
            @(negedge i_mclk);
            n++;
        end
        repeat (8) @(negedge i_mclk);
        check({what, " count"}, 16'(host_i.got.size()), 16'(exp_q.size()));
        foreach (exp_q[k]) check(what, 16'(host_i.got[k]), {7'h0, k == exp_q.size() - 1, exp_q[k]});
        exp_q.delete();
    endtask
    task automatic t_regs();
        logic [7:0] d;
        reg_rd(ADDR_CONFIG, d);
        check("config reset", {8'h0, d}, {8'h0, CFG_RESET});
        reg_wr(ADDR_STATUS, 8'hFF);
        reg_wr(4'h8, 8'h77);
        reg_rd(ADDR_STATUS, d);
        check("status", {8'h0, d}, 16'h0000);
        reg_rd(4'h8, d);
        check("unmapped", {8'h0, d}, 16'h0000);
        reg_rd(ADDR_CONFIG, d);
        check("config kept", {8'h0, d}, {8'h0, CFG_RESET});
        // write then read with no gap between the strobes
        @(posedge i_mclk);
        i_reg_addr <= ADDR_CONFIG;
        i_reg_wdata <= 8'h25;
        i_reg_wr <= 1'b1;
        @(posedge i_mclk);
        i_reg_wr <= 1'b0;
        i_reg_rd <= 1'b1;
        @(posedge i_mclk);
        i_reg_rd <= 1'b0;
        #1 d = o_reg_rdata;
        check("config back", {8'h0, d}, 16'h0025);
    endtask
    task automatic t_single();
        i_reading <= 64'h3FF0_0000_0000_0000;
        for (int sw = 0; sw < 2; sw++) begin
            add_s("#0");
            add_v(64'h3F80_0000, 4, sw[0]);
            add_v(64'h0, 4, sw[0]);
            run(sw[0] ? 8'h35 : 8'h31, "single");
        end
    endtask
    task automatic t_double_full();
        i_reading <= 64'hC000_0000_0000_0000;
        i_scanning <= 1'b1;
        i_chan <= 10'h005;
        i_chan_ext <= 1'b1;
        hold <= 1'b1;
        add_s("#0");
        add_v(64'hC000_0000_0000_0000, 8, 1'b1);
        add_v(64'h4014_0000_0000_0000, 8, 1'b1);
        run(8'h76, "double");
    endtask
    task automatic t_text();
        i_scanning <= 1'b0;
        i_chan_ext <= 1'b0;
        i_overflow <= 1'b1;
        add_s("+9.9E+37,0000INT");
        run(8'h74, "text ovf");
        i_overflow <= 1'b0;
        i_from_buffer <= 1'b0;
        add_s("+1.23E+01VDC");
        run(8'h52, "query");
        i_from_buffer <= 1'b1;
        i_scanning <= 1'b1;
        i_chan <= 10'h3E7;
        add_s("0999");
        run(8'h23, "chan only");
    endtask
    initial begin
        #200_000;
        err_total++;
        final_report();
    end
    initial begin
        repeat (5) @(posedge i_mclk);
        i_sys_rst <= 1'b0;
        t_regs();
        t_single();
        t_double_full();
        t_text();
        final_report();
    end
endmodule
